// file: rtl/wdm_defines.svh
// Purpose: offsets, field positions, reset values and limits of the word data move unit
// Assumes: included by bare name
// Notes:   definitions only
`ifndef WDM_DEFINES_SVH
`define WDM_DEFINES_SVH
// register byte offsets
`define WDM_CTRL_OFS       8'h00
`define WDM_OPA_OFS        8'h04
`define WDM_OPB_OFS        8'h08
`define WDM_OPC_OFS        8'h0C
`define WDM_STATUS_OFS     8'h10
`define WDM_MADDR_OFS      8'h14
`define WDM_MDATA_OFS      8'h18
// control fields
`define WDM_CTRL_START_BIT 31
`define WDM_CTRL_EXEC_BIT  8
// status fields
`define WDM_ST_BUSY_BIT    0
`define WDM_ST_DONE_BIT    1
`define WDM_ST_ERR_BIT     2
`define WDM_ST_EQ_BIT      3
// data areas and limits
`define WDM_DM_AREA        3'h3
`define WDM_TC_AREA        3'h4
`define WDM_DM_SIZE        14'h0200
`define WDM_BIT_MAX        14'h000F
`define WDM_RESP_OKAY      2'h0
`define WDM_RESP_SLVERR    2'h2
`define WDM_OPR_RESET      32'h0000_0000
`endif

// file: rtl/wdm_pkg.sv
// Purpose: types shared by the word data move unit
// Assumes: nothing
// Notes:   operand register layout is a packed struct
package wdm_pkg;
  typedef enum logic [3:0] {
    OP_WORD_SHIFT, OP_PLAIN_MOVE, OP_INVERTED_MOVE, OP_BLOCK_FILL, OP_BLOCK_COPY,
    OP_WORD_SWAP, OP_DISTRIBUTE, OP_COLLECT, OP_BIT_MOVE
  } wdm_op_t;
  typedef enum logic [1:0] {S_IDLE, S_RES, S_CHK, S_RUN} wdm_state_t;
  typedef enum logic [1:0] {SRC_TMP, SRC_MEM, SRC_SHIFT} wdm_src_t;
  typedef struct packed {
    logic [13:0] rsvd;
    logic        indirect;
    logic        imm;
    logic [15:0] value;
  } wdm_opr_t;
endpackage

// file: rtl/wdm_word_data_move_unit.sv
// Purpose: executes word data movement operations on an internal data memory
// Assumes: AXI4-Lite register access, one clock, synchronous active-low reset
// Notes:   memory reads are asynchronous; at most one word is written per enabled cycle
`include "wdm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module wdm_word_data_move_unit
  import wdm_pkg::*;
#(
  parameter int AW     = 12,
  parameter int AREA_W = 3
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  localparam int LOW_W = AW - AREA_W;
  localparam logic [AW-1:0] DM_BASE = AW'(`WDM_DM_AREA) << LOW_W;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic bcd_ok(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (v[4*k +: 4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction
  function automatic logic [13:0] bcd_val(input logic [15:0] v);
    return 14'(v[15:12]) * 14'h03E8 + 14'(v[11:8]) * 14'h0064 +
           14'(v[7:4]) * 14'h000A + 14'(v[3:0]);
  endfunction
  function automatic logic [AREA_W-1:0] area_of(input logic [AW-1:0] a);
    return a[AW-1:LOW_W];
  endfunction
  function automatic logic in_area(input logic [AW-1:0] base, input logic [13:0] off);
    logic [16:0] s;
    s = 17'(base) + 17'(off);
    return (s >> LOW_W) == 17'(area_of(base));
  endfunction
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) r[8*k +: 8] = n[8*k +: 8];
    end
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [15:0]   mem [0:(1<<AW)-1];
  wdm_state_t    st_ff;
  wdm_op_t       op_ff;
  logic          exec_ff, ind_err_ff, swap_ph_ff, down_ff;
  logic          err_ff, eq_ff, done_ff;
  wdm_opr_t      opr_ff [3];
  logic [AW-1:0] adr_ff [3];
  logic [AW-1:0] idx_ff, sp_ff, last_ff, lo_ff, hi_ff, maddr_ff;
  logic [15:0]   tmp_ff;
  wdm_src_t      mode_ff;
  logic          aw_ok_ff, w_ok_ff;
  logic [7:0]    waddr_ff;
  logic [31:0]   wdat_ff;
  logic [3:0]    wstrb_ff;
  logic          awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]    bresp_ff, rresp_ff;
  logic [31:0]   rdata_ff;

  // ****************************************
  // operand resolution
  // ****************************************
  logic [2:0]    res_bad;
  logic [AW-1:0] res_adr [3];
  logic [15:0]   val_w [3];
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_opr
    logic [15:0] ptr_w;
    logic        ind_w;
    assign ptr_w = mem[opr_ff[gi].value[AW-1:0]];
    assign ind_w = opr_ff[gi].indirect && !opr_ff[gi].imm;
    assign res_bad[gi] = ind_w && (!bcd_ok(ptr_w) || bcd_val(ptr_w) >= `WDM_DM_SIZE);
    assign res_adr[gi] = ind_w ? DM_BASE + AW'(bcd_val(ptr_w)) : opr_ff[gi].value[AW-1:0];
    assign val_w[gi] = opr_ff[gi].imm ? opr_ff[gi].value : mem[adr_ff[gi]];
  end

  // ****************************************
  // operation check and set-up
  // ****************************************
  logic          ck_err, ck_down;
  logic [AW-1:0] ck_idx, ck_sp, ck_last;
  logic [15:0]   ck_tmp;
  wdm_src_t      ck_mode;
  logic [13:0]   n_w, bl_w, bh_w;
  assign n_w  = bcd_val(op_ff == OP_BLOCK_COPY ? val_w[0] :
                        op_ff == OP_COLLECT ? val_w[1] : val_w[2]);
  assign bl_w = bcd_val({8'h00, val_w[1][7:0]});
  assign bh_w = bcd_val({8'h00, val_w[1][15:8]});
  always_comb begin
    ck_err  = 1'b0;
    ck_down = 1'b0;
    ck_idx  = adr_ff[1];
    ck_sp   = adr_ff[0];
    ck_last = adr_ff[1];
    ck_tmp  = val_w[0];
    ck_mode = SRC_TMP;
    case (op_ff)
      OP_WORD_SHIFT: begin
        ck_err  = area_of(adr_ff[0]) != area_of(adr_ff[1]) || adr_ff[0] > adr_ff[1];
        ck_down = 1'b1;
        ck_sp   = adr_ff[1] - AW'(1);
        ck_last = adr_ff[0];
        ck_mode = SRC_SHIFT;
      end
      OP_PLAIN_MOVE: ck_err = area_of(adr_ff[1]) == `WDM_TC_AREA;
      OP_INVERTED_MOVE: begin
        ck_err = area_of(adr_ff[1]) == `WDM_TC_AREA;
        ck_tmp = ~val_w[0];
      end
      OP_BLOCK_FILL: begin
        // timer/counter area deliberately not excluded here
        ck_err  = area_of(adr_ff[1]) != area_of(adr_ff[2]) || adr_ff[1] > adr_ff[2];
        ck_last = adr_ff[2];
      end
      OP_BLOCK_COPY: begin
        ck_err  = !bcd_ok(val_w[0]) || !in_area(adr_ff[1], n_w) ||
                  !in_area(adr_ff[2], n_w);
        ck_idx  = adr_ff[2];
        ck_sp   = adr_ff[1];
        ck_last = adr_ff[2] + AW'(n_w);
        ck_mode = SRC_MEM;
      end
      OP_WORD_SWAP: begin
        ck_idx  = adr_ff[0];
        ck_sp   = adr_ff[1];
        ck_mode = SRC_MEM;
      end
      OP_DISTRIBUTE: begin
        ck_err  = !bcd_ok(val_w[2]) || !in_area(adr_ff[1], n_w);
        ck_idx  = adr_ff[1] + AW'(n_w);
        ck_last = adr_ff[1] + AW'(n_w);
      end
      OP_COLLECT: begin
        ck_err  = !bcd_ok(val_w[1]) || !in_area(adr_ff[0], n_w);
        ck_idx  = adr_ff[2];
        ck_last = adr_ff[2];
        ck_sp   = adr_ff[0] + AW'(n_w);
        ck_mode = SRC_MEM;
      end
      OP_BIT_MOVE: begin
        ck_err  = !bcd_ok(val_w[1]) || bl_w > `WDM_BIT_MAX || bh_w > `WDM_BIT_MAX;
        ck_idx  = adr_ff[2];
        ck_last = adr_ff[2];
        ck_tmp  = val_w[2];
        ck_tmp[bh_w[3:0]] = val_w[0][bl_w[3:0]];
      end
      default: ck_err = 1'b1;
    endcase
  end

  // ****************************************
  // execution engine
  // ****************************************
  logic          eng_we, run_last, eq_op, start_req, wr_fire, go_w;
  logic [AW-1:0] eng_wa;
  logic [15:0]   eng_wd;
  assign eng_we   = st_ff == S_RUN;
  assign eng_wa   = idx_ff;
  assign eng_wd   = mode_ff == SRC_TMP ? tmp_ff :
                    (mode_ff == SRC_SHIFT && idx_ff == last_ff) ? 16'h0000 : mem[sp_ff];
  assign run_last = idx_ff == last_ff && !(op_ff == OP_WORD_SWAP && !swap_ph_ff);
  assign eq_op    = op_ff == OP_PLAIN_MOVE || op_ff == OP_INVERTED_MOVE ||
                    op_ff == OP_DISTRIBUTE || op_ff == OP_COLLECT;
  assign go_w     = exec_ff && !ck_err && !ind_err_ff;
  assign wr_fire  = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign start_req = wr_fire && waddr_ff == `WDM_CTRL_OFS && wstrb_ff[3] &&
                     wdat_ff[`WDM_CTRL_START_BIT] && st_ff == S_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff      <= S_IDLE;
      op_ff      <= OP_WORD_SHIFT;
      exec_ff    <= 1'b0;
      ind_err_ff <= 1'b0;
      swap_ph_ff <= 1'b0;
      down_ff    <= 1'b0;
      idx_ff     <= '0;
      sp_ff      <= '0;
      last_ff    <= '0;
      lo_ff      <= '0;
      hi_ff      <= '0;
      tmp_ff     <= 16'h0000;
      mode_ff    <= SRC_TMP;
      for (int k = 0; k < 3; k++) adr_ff[k] <= '0;
    end else if (ce) begin
      case (st_ff)
        S_IDLE: if (start_req) begin
          op_ff   <= wdm_op_t'(wdat_ff[3:0]);
          exec_ff <= wdat_ff[`WDM_CTRL_EXEC_BIT];
          st_ff   <= S_RES;
        end
        S_RES: begin
          for (int k = 0; k < 3; k++) adr_ff[k] <= res_adr[k];
          ind_err_ff <= |res_bad;
          st_ff      <= S_CHK;
        end
        S_CHK: begin
          idx_ff     <= ck_idx;
          sp_ff      <= ck_sp;
          last_ff    <= ck_last;
          lo_ff      <= ck_idx < ck_last ? ck_idx : ck_last;
          hi_ff      <= ck_idx < ck_last ? ck_last : ck_idx;
          tmp_ff     <= ck_tmp;
          mode_ff    <= ck_mode;
          down_ff    <= ck_down;
          swap_ph_ff <= 1'b0;
          st_ff      <= go_w ? S_RUN : S_IDLE;
        end
        S_RUN: begin
          if (run_last) begin
            st_ff <= S_IDLE;
          end else if (op_ff == OP_WORD_SWAP) begin
            // second half writes the held copy of the first word
            idx_ff     <= last_ff;
            mode_ff    <= SRC_TMP;
            swap_ph_ff <= 1'b1;
          end else begin
            idx_ff <= down_ff ? idx_ff - AW'(1) : idx_ff + AW'(1);
            sp_ff  <= down_ff ? sp_ff - AW'(1) : sp_ff + AW'(1);
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // result flags
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_ff  <= 1'b0;
      eq_ff   <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      if (start_req) begin
        err_ff  <= 1'b0;
        done_ff <= 1'b0;
      end
      if (st_ff == S_CHK && exec_ff && (ck_err || ind_err_ff)) err_ff <= 1'b1;
      if (st_ff == S_CHK && !go_w) done_ff <= 1'b1;
      if (eng_we && eq_op) eq_ff <= eng_wd == 16'h0000;
      if (eng_we && run_last) done_ff <= 1'b1;
    end
  end

  // ****************************************
  // data memory
  // ****************************************
  // bus writes are dropped while busy so the engine owns every word it touches
  logic [31:0]   mdat_mrg;
  assign mdat_mrg = wmerge({16'h0000, mem[maddr_ff]}, wdat_ff, wstrb_ff);
  always_ff @(posedge aclk) begin
    if (aresetn && ce) begin
      if (eng_we) begin
        mem[eng_wa] <= eng_wd;
      end else if (wr_fire && st_ff == S_IDLE && waddr_ff == `WDM_MDATA_OFS) begin
        mem[maddr_ff] <= mdat_mrg[15:0];
      end
    end
  end

  // ****************************************
  // register file
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < 3; k++) opr_ff[k] <= `WDM_OPR_RESET;
      maddr_ff <= '0;
    end else if (ce && wr_fire && st_ff == S_IDLE) begin
      if (waddr_ff == `WDM_OPA_OFS) opr_ff[0] <= wmerge(opr_ff[0], wdat_ff, wstrb_ff);
      else if (waddr_ff == `WDM_OPB_OFS) opr_ff[1] <= wmerge(opr_ff[1], wdat_ff, wstrb_ff);
      else if (waddr_ff == `WDM_OPC_OFS) opr_ff[2] <= wmerge(opr_ff[2], wdat_ff, wstrb_ff);
      else if (waddr_ff == `WDM_MADDR_OFS) maddr_ff <= AW'(wmerge(32'(maddr_ff), wdat_ff, wstrb_ff));
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    return a == `WDM_CTRL_OFS || a == `WDM_OPA_OFS || a == `WDM_OPB_OFS ||
           a == `WDM_OPC_OFS || a == `WDM_STATUS_OFS || a == `WDM_MADDR_OFS ||
           a == `WDM_MDATA_OFS;
  endfunction

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (araddr == `WDM_CTRL_OFS) rd_mux = {23'h00_0000, exec_ff, 4'h0, op_ff};
    else if (araddr == `WDM_OPA_OFS) rd_mux = opr_ff[0];
    else if (araddr == `WDM_OPB_OFS) rd_mux = opr_ff[1];
    else if (araddr == `WDM_OPC_OFS) rd_mux = opr_ff[2];
    else if (araddr == `WDM_STATUS_OFS) rd_mux = {28'h000_0000, eq_ff, err_ff, done_ff,
                                                   st_ff != S_IDLE};
    else if (araddr == `WDM_MADDR_OFS) rd_mux = 32'(maddr_ff);
    else if (araddr == `WDM_MDATA_OFS) rd_mux = {16'h0000, mem[maddr_ff]};
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff  <= 1'b0;
      waddr_ff <= 8'h00;
      wdat_ff  <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `WDM_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready_ff) begin
        aw_ok_ff   <= 1'b1;
        waddr_ff   <= {awaddr[7:2], 2'b00};
        awready_ff <= 1'b0;
      end else if (!aw_ok_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (wvalid && wready_ff) begin
        w_ok_ff   <= 1'b1;
        wdat_ff   <= wdata;
        wstrb_ff  <= wstrb;
        wready_ff <= 1'b0;
      end else if (!w_ok_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      if (wr_fire) begin
        aw_ok_ff  <= 1'b0;
        w_ok_ff   <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= mapped(waddr_ff) ? `WDM_RESP_OKAY : `WDM_RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `WDM_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= rd_mux;
        rresp_ff   <= mapped({araddr[7:2], 2'b00}) ? `WDM_RESP_OKAY : `WDM_RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
      end else if (!rvalid_ff) begin
        arready_ff <= 1'b1;
      end
    end
  end

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  // ****************************************
  // assertions
  // ****************************************
  property p_skip;
    @(posedge aclk) disable iff (!aresetn)
    (st_ff == S_CHK && ce && !exec_ff) |=> (st_ff == S_IDLE && done_ff && !err_ff);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped operation did not end cleanly");
  property p_shift_err;
    @(posedge aclk) disable iff (!aresetn)
    (st_ff == S_CHK && ce && exec_ff && op_ff == OP_WORD_SHIFT && adr_ff[0] > adr_ff[1])
      |=> (err_ff && st_ff == S_IDLE);
  endproperty
  a_shift_err: assert property (p_shift_err) else $error("bad shift range not flagged");
  property p_ind_err;
    @(posedge aclk) disable iff (!aresetn)
    (st_ff == S_CHK && ce && exec_ff && ind_err_ff) |=> (err_ff && st_ff == S_IDLE);
  endproperty
  a_ind_err: assert property (p_ind_err) else $error("indirect error not flagged");
  property p_dst_only;
    @(posedge aclk) disable iff (!aresetn)
    eng_we |-> (eng_wa >= lo_ff && eng_wa <= hi_ff);
  endproperty
  a_dst_only: assert property (p_dst_only) else $error("write outside destination");
  property p_move_eq;
    @(posedge aclk) disable iff (!aresetn)
    (eng_we && ce && (op_ff == OP_PLAIN_MOVE || op_ff == OP_INVERTED_MOVE))
      |=> (eq_ff == ($past(eng_wd) == 16'h0000));
  endproperty
  a_move_eq: assert property (p_move_eq) else $error("equal flag wrong after move");
  property p_inv;
    @(posedge aclk) disable iff (!aresetn)
    (st_ff == S_CHK && ce && go_w && op_ff == OP_INVERTED_MOVE)
      |=> (eng_we && eng_wd == ~$past(val_w[0]));
  endproperty
  a_inv: assert property (p_inv) else $error("inverted move data wrong");
  property p_no_tc;
    @(posedge aclk) disable iff (!aresetn)
    (eng_we && (op_ff == OP_PLAIN_MOVE || op_ff == OP_INVERTED_MOVE))
      |-> (area_of(eng_wa) != `WDM_TC_AREA);
  endproperty
  a_no_tc: assert property (p_no_tc) else $error("move wrote a present value");
  property p_swap;
    @(posedge aclk) disable iff (!aresetn)
    (eng_we && ce && op_ff == OP_WORD_SWAP && !swap_ph_ff && !run_last)
      |=> (eng_we && swap_ph_ff && eng_wa == adr_ff[1] && eng_wd == $past(tmp_ff));
  endproperty
  a_swap: assert property (p_swap) else $error("swap second half wrong");
  property p_shift_zero;
    @(posedge aclk) disable iff (!aresetn)
    (eng_we && op_ff == OP_WORD_SHIFT && eng_wa == adr_ff[0]) |-> (eng_wd == 16'h0000);
  endproperty
  a_shift_zero: assert property (p_shift_zero) else $error("shift start not zeroed");
endmodule // wdm_word_data_move_unit
`default_nettype wire

// file: bench/wdm_seq_model.sv
// Purpose: sequencer model, axi4-lite master cycles into the unit
// Assumes: one clock; requests change just after rising edges
// Notes:   waits until answered; the bench timeout catches a hang
`timescale 1ns/1ps
`default_nettype none
module wdm_seq_model (
  // clock
  input  wire logic        aclk,
  // write
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // aw and w released one by one as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!got) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!got) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
      end
    end
  endtask
endmodule // wdm_seq_model
`default_nettype wire

// file: bench/wdm_word_data_move_unit_test.sv
// Purpose: self-checking bench of the word data move unit
// Assumes: 250 MHz aclk, reset held 10 cycles
// Notes:   data memory is not reset, so every checked word is written first
`include "wdm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module wdm_word_data_move_unit_test import wdm_pkg::*; ;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, s;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int err_total, comparisons, cyc;
  wdm_word_data_move_unit i_dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready);
  wdm_seq_model i_seq (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a run far beyond some 700 cycles is a hang
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] im(input logic [15:0] v);
    return {16'h0000, v} | 32'h0001_0000;
  endfunction
  task automatic mw(input logic [15:0] a, v);
    i_seq.wr(`WDM_MADDR_OFS, a, r);
    i_seq.wr(`WDM_MDATA_OFS, v, r);
  endtask
  task automatic mc(input logic [15:0] a, v);
    logic [31:0] d;
    i_seq.wr(`WDM_MADDR_OFS, a, r);
    i_seq.rd(`WDM_MDATA_OFS, d, r);
    chk("mem", d, v);
  endtask
  task automatic op(input wdm_op_t o, input logic x, input logic [31:0] a, b, c,
                    input logic er);
    i_seq.wr(`WDM_OPA_OFS, a, r);
    i_seq.wr(`WDM_OPB_OFS, b, r);
    i_seq.wr(`WDM_OPC_OFS, c, r);
    i_seq.wr(`WDM_CTRL_OFS, {1'b1, 22'h00_0000, x, 4'h0, o}, r);
    s = '0;
    for (int n = 0; n < 40 && s[`WDM_ST_DONE_BIT] !== 1'b1; n++)
      i_seq.rd(`WDM_STATUS_OFS, s, r);
    chk("error_flag", s[`WDM_ST_ERR_BIT], er);
  endtask
  initial begin
    {aresetn, ce, err_total, comparisons, cyc} = '0;
    ce = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    i_seq.wr(8'h1C, 32'h0000_0000, r);
    chk("unmapped", r, `WDM_RESP_SLVERR);
    i_seq.rd(8'h1C, s, r);
    chk("unmapped_rd", r, `WDM_RESP_SLVERR);
    chk("unmapped_data", s, 32'h0000_0000);
    mw(16'h0600, 16'h1234);
    op(OP_PLAIN_MOVE, 1'b1, 16'h0600, 16'h0601, 0, 1'b0);
    mc(16'h0601, 16'h1234);
    mc(16'h0600, 16'h1234);
    chk("equal_flag", s[`WDM_ST_EQ_BIT], 1'b0);
    op(OP_INVERTED_MOVE, 1'b1, im(16'hFFFF), 16'h0602, 0, 1'b0);
    mc(16'h0602, 16'h0000);
    chk("equal_flag", s[`WDM_ST_EQ_BIT], 1'b1);
    op(OP_PLAIN_MOVE, 1'b0, im(16'h5555), 16'h0601, 0, 1'b0);
    mc(16'h0601, 16'h1234);
    op(OP_BLOCK_FILL, 1'b1, im(16'h0007), 16'h0800, 16'h0801, 1'b0);
    mc(16'h0801, 16'h0007);
    op(OP_PLAIN_MOVE, 1'b1, im(16'h0001), 16'h0800, 0, 1'b1);
    mc(16'h0800, 16'h0007);
    op(OP_BLOCK_FILL, 1'b1, im(16'h0009), 16'h0801, 16'h0800, 1'b1);
    mc(16'h0800, 16'h0007);
    mw(16'h0620, 16'h000A);
    mw(16'h0621, 16'h000B);
    mw(16'h0622, 16'h000C);
    op(OP_WORD_SHIFT, 1'b1, 16'h0620, 16'h0622, 0, 1'b0);
    mc(16'h0620, 16'h0000);
    mc(16'h0622, 16'h000B);
    op(OP_WORD_SHIFT, 1'b1, 16'h07FF, 16'h0800, 0, 1'b1);
    op(OP_WORD_SWAP, 1'b1, 16'h0620, 16'h0621, 0, 1'b0);
    mc(16'h0620, 16'h000A);
    mc(16'h0621, 16'h0000);
    // source 0620..0622 and destination 0660..0662 kept apart
    op(OP_BLOCK_COPY, 1'b1, im(16'h0002), 16'h0620, 16'h0660, 1'b0);
    mc(16'h0662, 16'h000B);
    op(OP_BLOCK_COPY, 1'b1, im(16'h000A), 16'h0620, 16'h0660, 1'b1);
    op(OP_DISTRIBUTE, 1'b1, im(16'hABCD), 16'h0630, im(16'h0012), 1'b0);
    mc(16'h063C, 16'hABCD);
    chk("equal_flag", s[`WDM_ST_EQ_BIT], 1'b0);
    op(OP_DISTRIBUTE, 1'b1, im(16'h0000), 16'h07FF, im(16'h0001), 1'b1);
    // a zero word first, so the flag must visibly rise and then fall again
    op(OP_COLLECT, 1'b1, 16'h0620, im(16'h0001), 16'h0641, 1'b0);
    mc(16'h0641, 16'h0000);
    chk("equal_flag", s[`WDM_ST_EQ_BIT], 1'b1);
    op(OP_COLLECT, 1'b1, 16'h0630, im(16'h0012), 16'h0640, 1'b0);
    mc(16'h0640, 16'hABCD);
    chk("equal_flag", s[`WDM_ST_EQ_BIT], 1'b0);
    op(OP_COLLECT, 1'b1, 16'h0630, im(16'h001B), 16'h0640, 1'b1);
    mw(16'h0650, 16'h0001);
    op(OP_BIT_MOVE, 1'b1, im(16'h0008), im(16'h1503), 16'h0650, 1'b0);
    mc(16'h0650, 16'h8001);
    op(OP_BIT_MOVE, 1'b1, im(16'h0008), im(16'h0016), 16'h0650, 1'b1);
    mw(16'h0670, 16'h001F);
    op(OP_PLAIN_MOVE, 1'b1, 32'h0002_0670, 16'h0671, 0, 1'b1);
    // pointer 0001 resolves to the second word of the data memory area
    mw(16'h0671, 16'h0001);
    op(OP_PLAIN_MOVE, 1'b1, 32'h0002_0671, 16'h0672, 0, 1'b0);
    mc(16'h0672, 16'h1234);
    mw(16'h0673, 16'h0512);
    op(OP_PLAIN_MOVE, 1'b1, 32'h0002_0673, 16'h0674, 0, 1'b1);
    end_of_test();
  end
endmodule // wdm_word_data_move_unit_test
`default_nettype wire
